// ==== hsca_ee_model.sv ====
// behavioural spi mode-0 serial eeprom with write-enable latch
// assumes a mode-0 master on select, clock and data
`timescale 1ns/1ps
module hsca_ee_model #(
  parameter int BUSY_POLLS = 3
) (
  // spi pins
  input wire logic eeCsN,
  input wire logic eeSclk,
  input wire logic eeMosi,
  output logic eeMiso
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] op;
  logic [7:0] outB;
  logic [15:0] addr;
  logic wel;
  int busy;
  int n;

  ////////////////////////////////////////////////////////////////
  // byte 0 left blank so the stored image never validates
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    wel = 1'b0;
    busy = 0;
    eeMiso = 1'b0;
    outB = 8'h55;
    op = 8'h00;
    n = 0;
  end

  always @(negedge eeCsN) begin
    n = 0;
    outB = 8'h55;
  end

  // released line flips so a stale bit is never mistaken for data
  always @(posedge eeCsN) begin
    if (op == 8'h02 && wel) begin
      wel = 1'b0;
      busy = BUSY_POLLS;
    end
    eeMiso = ~eeMiso;
  end

  always @(posedge eeSclk) begin
    sh = {sh[6:0], eeMosi};
    n = n + 1;
    if (n % 8 == 0) begin
      if (n == 8) op = sh;
      if (n == 8 && sh == 8'h06) wel = 1'b1;
      if (op == 8'h05) begin
        outB = {6'h00, wel, busy > 0};
        if (busy > 0) busy = busy - 1;
      end
      if (n == 16) addr[15:8] = sh;
      if (n == 24) addr[7:0] = sh;
      if (n >= 24 && op == 8'h03) begin
        outB = mem[addr[7:0]];
        addr = addr + 16'h1;
      end
      if (n >= 32 && op == 8'h02 && wel) begin
        mem[addr[7:0]] = sh;
        addr = addr + 16'h1;
      end
    end
  end

  always @(negedge eeSclk) begin
    eeMiso = outB[7];
    outB = {outB[6:0], 1'b1};
  end
endmodule

// ==== hsca_monitor.sv ====
// assertion checker for the host serial config access block
// sees only top-level ports; bound from the testbench top file
`timescale 1ns/1ps
module hsca_monitor import hsca_pkg::*; #(
  parameter int BIT_CYCLES = BAUD_DIV
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // serial pins
  input wire logic hostTxd,
  input wire logic eeCsN,
  input wire logic eeSclk,
  // voltage and status
  input wire logic [5:0] voltSelPins,
  input wire logic softStartDone,
  input wire logic [5:0] voltTarget,
  input wire logic [5:0] pinVoltCode,
  input wire logic extMemPresent,
  input wire logic loadDone
);
  int lowCnt;
  int hiCnt;
  int csCnt;
  logic [1:0] upCnt;

  ////////////////////////////////////////////////////////////////
  // run-length counters and a cycles-since-reset count; long runs cannot be unrolled as repetitions
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lowCnt <= 0;
      hiCnt <= 0;
      csCnt <= 0;
      upCnt <= 2'h0;
    end else begin
      lowCnt <= hostTxd ? 0 : lowCnt + 1;
      hiCnt <= eeSclk ? hiCnt + 1 : 0;
      csCnt <= eeCsN ? 0 : csCnt + 1;
      upCnt <= (upCnt == 2'h3) ? upCnt : upCnt + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  AST_TXD_BITS: assert property ($rose(hostTxd) |-> lowCnt > 0 && lowCnt % BIT_CYCLES == 0)
    else $error("txd low run is not a whole number of bits");
  AST_CS_LEAD: assert property ($rose(eeSclk) |-> csCnt >= EE_CSSU_CYC - 1)
    else $error("eeprom clock rose too soon after select");
  AST_SCLK_HALF: assert property ($fell(eeSclk) |-> hiCnt == EE_HALF_CYC)
    else $error("eeprom clock high phase has wrong length");
  AST_SCLK_SEL: assert property (eeSclk |-> !eeCsN)
    else $error("eeprom clock toggles while deselected");
  AST_LOAD_HOLD: assert property (loadDone |=> loadDone)
    else $error("load done dropped");
  AST_EXT_FIRST: assert property ($rose(extMemPresent) |-> !loadDone)
    else $error("memory present set after load done");
  AST_PIN_TRACK: assert property ($stable(voltSelPins) [*3] |-> pinVoltCode == voltSelPins)
    else $error("pin code register does not follow pins");
  AST_VT_HOLD: assert property (upCnt == 2'h3 && !softStartDone |-> $stable(voltTarget))
    else $error("voltage target moved during soft start");

  cover property ($rose(loadDone));
  cover property ($fell(eeCsN));
  cover property ($fell(hostTxd));
endmodule

// ==== hsca_pkg.sv ====
// shared constants and types of the host serial configuration access block
// assumes a 200 MHz system clock and an spi-mode-0 serial eeprom
package hsca_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_BPS = 115_200;
  localparam int BAUD_DIV = CLK_HZ / BAUD_BPS;
  localparam int TIMEOUT_MS = 50;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int EE_PERIOD_NS = 480;
  localparam int EE_CSSU_NS = 480;
  localparam int EE_CSH_NS = 720;
  localparam int EE_HALF_CYC = EE_PERIOD_NS / 2 / CLK_PERIOD_NS;
  localparam int EE_CSSU_CYC = (EE_CSSU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_CSH_CYC = (EE_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BUS = 8'h01;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam int SR_WEL_BIT = 1;
  localparam int SR_WIP_BIT = 0;
  localparam int MEM_DEPTH = 4096;
  localparam logic [15:0] NV_BASE = 16'h0900;
  localparam int NV_SIZE = 128;
  localparam logic [15:0] VCODE_ADDR = 16'h0880;
  localparam logic [15:0] MSTAT_ADDR = 16'h0881;
  localparam int MSTAT_EXT_BIT = 0;
  localparam int MSTAT_DONE_BIT = 1;
  localparam logic [7:0] NV_CODE_DEF = 8'ha5;
  localparam logic [8:0] LOAD_HDR = 9'h004;
  typedef struct packed {
    logic vld;
    logic [15:0] addr;
    logic [7:0] data;
  } hsca_memwr_t;
  typedef enum logic [7:0] {
    H_CMD = 8'h01, H_AL = 8'h02, H_AH = 8'h04, H_DATA = 8'h08,
    H_EXEC = 8'h10, H_NVWAIT = 8'h20, H_TXERR = 8'h40, H_TXDATA = 8'h80
  } hsca_hst_t;
  typedef enum logic [3:0] {
    E_GAP = 4'h1, E_LEAD = 4'h2, E_FRAME = 4'h4, E_READY = 4'h8
  } hsca_est_t;
  typedef enum logic [2:0] {
    K_NONE, K_PWREN, K_PRDSR, K_LOAD, K_WWREN, K_WRITE, K_POLL, K_VERIFY
  } hsca_kind_t;
endpackage

// ==== hsca_top.sv ====
// host serial command port, memory map, eeprom loader and write-through
// assumes all inputs synchronous to clock; monitor writes may stay valid for several cycles
`timescale 1ns/1ps
module hsca_top import hsca_pkg::*; #(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  // bit-time counters are 11 bits wide, so divisors above 2048 do not fit
  parameter int BIT_CYCLES = BAUD_DIV,
  parameter logic [7:0] NV_CODE = NV_CODE_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // host serial line
  input wire logic hostRxd,
  output logic hostTxd,
  // serial eeprom
  input wire logic eeMiso,
  output logic eeCsN,
  output logic eeSclk,
  output logic eeMosi,
  // monitor write port
  input wire hsca_pkg::hsca_memwr_t monWr,
  // voltage select
  input wire logic [5:0] voltSelPins,
  input wire logic softStartDone,
  output logic [5:0] voltTarget,
  output logic [5:0] pinVoltCode,
  // status
  output logic extMemPresent,
  output logic loadDone
);
  import hsca_pkg::*;

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam int AW = $clog2(MEM_DEPTH);

  function automatic logic isNv(input logic [15:0] a);
    return a >= NV_BASE && a < NV_BASE + 16'(NV_SIZE);
  endfunction

  function automatic logic [8:0] frameLen(input hsca_kind_t k);
    unique case (k)
      K_PRDSR, K_POLL: return 9'd2;
      K_LOAD: return LOAD_HDR + 9'(NV_SIZE);
      K_WRITE, K_VERIFY: return LOAD_HDR;
      default: return 9'd1;
    endcase
  endfunction

  function automatic logic [7:0] txByte(input hsca_kind_t k, input logic [8:0] i,
                                       input logic [15:0] ea, input logic [7:0] d);
    if (i == 9'd0) begin
      unique case (k)
        K_PWREN, K_WWREN: return OP_WREN;
        K_PRDSR, K_POLL: return OP_RDSR;
        K_WRITE: return OP_WRITE;
        default: return OP_READ;
      endcase
    end
    if (k == K_LOAD) return 8'h00;
    if (i == 9'd1) return ea[15:8];
    if (i == 9'd2) return ea[7:0];
    return (k == K_WRITE) ? d : 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // host uart

  logic rxBusy_r, rxBusy_nxt, rxDone_r, rxDone_nxt;
  logic [10:0] rxCnt_r, rxCnt_nxt, txCnt_r, txCnt_nxt;
  logic [3:0] rxIdx_r, rxIdx_nxt, txIdx_r, txIdx_nxt;
  logic [7:0] rxSh_r, rxSh_nxt;
  logic txBusy_r, txBusy_nxt, hostTxd_r, hostTxd_nxt;
  logic [9:0] txSh_r, txSh_nxt;
  logic txLoad;
  logic [7:0] txData;

  always_comb begin
    rxBusy_nxt = rxBusy_r;
    rxCnt_nxt = rxCnt_r;
    rxIdx_nxt = rxIdx_r;
    rxSh_nxt = rxSh_r;
    rxDone_nxt = 1'b0;
    if (!rxBusy_r) begin
      if (!hostRxd) begin
        rxBusy_nxt = 1'b1;
        rxCnt_nxt = 11'(BIT_CYCLES / 2); // sample mid-bit
        rxIdx_nxt = 4'h0;
      end
    end else if (rxCnt_r != 11'h000) begin
      rxCnt_nxt = rxCnt_r - 11'h001;
    end else begin
      rxCnt_nxt = 11'(BIT_CYCLES - 1);
      rxIdx_nxt = rxIdx_r + 4'h1;
      if (rxIdx_r == 4'h0) begin
        rxBusy_nxt = !hostRxd;
      end else if (rxIdx_r <= 4'h8) begin
        rxSh_nxt = {hostRxd, rxSh_r[7:1]}; // lsb first
      end else begin
        rxBusy_nxt = 1'b0;
        rxDone_nxt = hostRxd; // bad stop bit drops the byte
      end
    end
    txBusy_nxt = txBusy_r;
    txCnt_nxt = txCnt_r;
    txIdx_nxt = txIdx_r;
    txSh_nxt = txSh_r;
    if (txLoad) begin
      txBusy_nxt = 1'b1;
      txSh_nxt = {1'b1, txData, 1'b0};
      txCnt_nxt = 11'(BIT_CYCLES - 1);
      txIdx_nxt = 4'h0;
    end else if (txBusy_r) begin
      if (txCnt_r != 11'h000) begin
        txCnt_nxt = txCnt_r - 11'h001;
      end else begin
        txCnt_nxt = 11'(BIT_CYCLES - 1);
        txSh_nxt = {1'b1, txSh_r[9:1]};
        txIdx_nxt = txIdx_r + 4'h1;
        txBusy_nxt = txIdx_r != 4'h9;
      end
    end
    hostTxd_nxt = txBusy_nxt ? txSh_nxt[0] : 1'b1;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxBusy_r <= 1'b0;
      rxDone_r <= 1'b0;
      rxCnt_r <= 11'h000;
      rxIdx_r <= 4'h0;
      rxSh_r <= 8'h00;
      txBusy_r <= 1'b0;
      txCnt_r <= 11'h000;
      txIdx_r <= 4'h0;
      txSh_r <= 10'h3ff;
      hostTxd_r <= 1'b1;
    end else begin
      rxBusy_r <= rxBusy_nxt;
      rxDone_r <= rxDone_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxIdx_r <= rxIdx_nxt;
      rxSh_r <= rxSh_nxt;
      txBusy_r <= txBusy_nxt;
      txCnt_r <= txCnt_nxt;
      txIdx_r <= txIdx_nxt;
      txSh_r <= txSh_nxt;
      hostTxd_r <= hostTxd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // host command interpreter

  hsca_hst_t hst_r, hst_nxt;
  logic cmdRd_r, cmdRd_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] wdat_r, wdat_nxt, err_r, err_nxt, rdat_r, rdat_nxt;
  logic [TW-1:0] toCnt_r, toCnt_nxt;
  logic toExp, eeStart;
  hsca_memwr_t hostWr;
  hsca_est_t est_r;
  logic ext_r, done_r, fail_r, ldPend_r;
  logic [7:0] mem [MEM_DEPTH];

  always_comb begin
    hst_nxt = hst_r;
    cmdRd_nxt = cmdRd_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    err_nxt = err_r;
    rdat_nxt = rdat_r;
    hostWr = '0;
    txLoad = 1'b0;
    txData = err_r;
    eeStart = 1'b0;
    toExp = toCnt_r == TW'(TIMEOUT_CYCLES);
    toCnt_nxt = rxDone_r ? '0 : (toExp ? toCnt_r : TW'(toCnt_r + 1'b1));
    unique case (hst_r)
      H_CMD: begin
        if (rxDone_r && (rxSh_r == CMD_READ || rxSh_r == CMD_WRITE)) begin
          cmdRd_nxt = rxSh_r == CMD_READ;
          hst_nxt = H_AL;
        end
      end
      H_AL: begin
        if (rxDone_r) begin
          addr_nxt[7:0] = rxSh_r;
          hst_nxt = H_AH;
        end else if (toExp) begin
          hst_nxt = H_CMD;
        end
      end
      H_AH: begin
        if (rxDone_r) begin
          addr_nxt[15:8] = rxSh_r;
          hst_nxt = cmdRd_r ? H_EXEC : H_DATA;
        end else if (toExp) begin
          hst_nxt = H_CMD;
        end
      end
      H_DATA: begin
        if (rxDone_r) begin
          wdat_nxt = rxSh_r;
          hst_nxt = H_EXEC;
        end else if (toExp) begin
          hst_nxt = H_CMD;
        end
      end
      H_EXEC: begin
        if (addr_r >= 16'(MEM_DEPTH)) begin
          err_nxt = ERR_BUS;
          hst_nxt = H_TXERR;
        end else if (isNv(addr_r) && !done_r) begin
          hst_nxt = H_EXEC;
        end else if (cmdRd_r) begin
          rdat_nxt = (addr_r == MSTAT_ADDR) ? 8'({done_r, ext_r}) : mem[addr_r[AW-1:0]];
          err_nxt = ERR_NONE;
          hst_nxt = H_TXERR;
        end else if (!monWr.vld && !ldPend_r) begin
          hostWr = '{vld: 1'b1, addr: addr_r, data: wdat_r};
          err_nxt = ERR_NONE;
          eeStart = isNv(addr_r) && ext_r;
          hst_nxt = eeStart ? H_NVWAIT : H_TXERR;
        end
      end
      H_NVWAIT: begin
        if (est_r == E_READY) begin
          err_nxt = fail_r ? ERR_BUS : ERR_NONE;
          hst_nxt = H_TXERR;
        end
      end
      H_TXERR: begin
        if (!txBusy_r) begin
          txLoad = 1'b1;
          hst_nxt = (cmdRd_r && err_r == ERR_NONE) ? H_TXDATA : H_CMD;
        end
      end
      H_TXDATA: begin
        if (!txBusy_r) begin
          txLoad = 1'b1;
          txData = rdat_r;
          hst_nxt = H_CMD;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hst_r <= H_CMD;
      cmdRd_r <= 1'b0;
      addr_r <= 16'h0000;
      wdat_r <= 8'h00;
      err_r <= ERR_NONE;
      rdat_r <= 8'h00;
      toCnt_r <= '0;
    end else begin
      hst_r <= hst_nxt;
      cmdRd_r <= cmdRd_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      err_r <= err_nxt;
      rdat_r <= rdat_nxt;
      toCnt_r <= toCnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // eeprom probe, load and write-through

  hsca_est_t est_nxt;
  hsca_kind_t kind_r, kind_nxt, nk_r, nk_nxt;
  logic [8:0] bi_r, bi_nxt;
  logic [8:0] wCnt_r, wCnt_nxt;
  logic [5:0] div_r, div_nxt;
  logic [3:0] half_r, half_nxt;
  logic [7:0] eTx_r, eTx_nxt, eRx_r, eRx_nxt, ldData_r, ldData_nxt;
  logic [15:0] ldAddr_r, ldAddr_nxt, eeAddr;
  logic csN_r, csN_nxt, sclk_r, sclk_nxt, mosi_r, mosi_nxt;
  logic ext_nxt, done_nxt, fail_nxt, ldPend_nxt, last;

  always_comb begin
    est_nxt = est_r;
    kind_nxt = kind_r;
    nk_nxt = nk_r;
    bi_nxt = bi_r;
    wCnt_nxt = wCnt_r;
    div_nxt = div_r;
    half_nxt = half_r;
    eTx_nxt = eTx_r;
    eRx_nxt = eRx_r;
    csN_nxt = csN_r;
    sclk_nxt = sclk_r;
    mosi_nxt = mosi_r;
    ext_nxt = ext_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    ldAddr_nxt = ldAddr_r;
    ldData_nxt = ldData_r;
    ldPend_nxt = ldPend_r && monWr.vld;
    eeAddr = addr_r - NV_BASE + 16'h0001;
    last = bi_r == frameLen(kind_r) - 9'd1;
    unique case (est_r)
      E_GAP: begin
        wCnt_nxt = wCnt_r + 9'd1;
        if (wCnt_r == 9'(EE_CSH_CYC - 1)) csN_nxt = 1'b1;
        if (wCnt_r == 9'(2 * EE_CSH_CYC - 1)) begin
          wCnt_nxt = 9'd0;
          if (nk_r == K_NONE) begin
            est_nxt = E_READY;
            done_nxt = 1'b1;
          end else begin
            kind_nxt = nk_r;
            est_nxt = E_LEAD;
            csN_nxt = 1'b0;
          end
        end
      end
      E_LEAD: begin
        wCnt_nxt = wCnt_r + 9'd1;
        if (wCnt_r == 9'(EE_CSSU_CYC - 1)) begin
          est_nxt = E_FRAME;
          div_nxt = 6'h00;
          half_nxt = 4'h0;
          bi_nxt = 9'd0;
          eTx_nxt = txByte(kind_r, 9'd0, eeAddr, wdat_r);
          mosi_nxt = eTx_nxt[7];
        end
      end
      E_FRAME: begin
        div_nxt = div_r + 6'h01;
        if (div_r == 6'(EE_HALF_CYC - 1)) begin
          div_nxt = 6'h00;
          half_nxt = half_r + 4'h1;
          sclk_nxt = !half_r[0];
          if (!half_r[0]) eRx_nxt = {eRx_r[6:0], eeMiso};
          if (half_r[0] && half_r != 4'hf) begin
            eTx_nxt = {eTx_r[6:0], 1'b0};
            mosi_nxt = eTx_nxt[7];
          end
          if (half_r == 4'hf) begin
            unique case (kind_r)
              K_PWREN: nk_nxt = K_PRDSR;
              K_PRDSR: begin
                ext_nxt = eRx_r[SR_WEL_BIT];
                nk_nxt = eRx_r[SR_WEL_BIT] ? K_LOAD : K_NONE;
              end
              K_LOAD: begin
                nk_nxt = K_NONE;
                if (bi_r == LOAD_HDR - 9'd1 && eRx_r != NV_CODE) last = 1'b1;
                if (bi_r >= LOAD_HDR) begin
                  ldPend_nxt = 1'b1;
                  ldAddr_nxt = NV_BASE + 16'(bi_r - LOAD_HDR);
                  ldData_nxt = eRx_r;
                end
              end
              K_WWREN: nk_nxt = K_WRITE;
              K_WRITE: nk_nxt = K_POLL;
              K_POLL: nk_nxt = eRx_r[SR_WIP_BIT] ? K_POLL : K_VERIFY;
              K_VERIFY: begin
                fail_nxt = eRx_r != wdat_r;
                nk_nxt = K_NONE;
              end
              default: nk_nxt = K_NONE;
            endcase
            bi_nxt = bi_r + 9'd1;
            half_nxt = 4'h0;
            if (last) begin
              est_nxt = E_GAP;
              wCnt_nxt = 9'd0;
            end else begin
              eTx_nxt = txByte(kind_r, bi_nxt, eeAddr, wdat_r);
              mosi_nxt = eTx_nxt[7];
            end
          end
        end
      end
      E_READY: begin
        if (eeStart) begin
          kind_nxt = K_WWREN;
          est_nxt = E_LEAD;
          csN_nxt = 1'b0;
          wCnt_nxt = 9'd0;
          fail_nxt = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      est_r <= E_GAP;
      kind_r <= K_NONE;
      nk_r <= K_PWREN;
      bi_r <= 9'd0;
      wCnt_r <= 9'd0;
      div_r <= 6'h00;
      half_r <= 4'h0;
      eTx_r <= 8'h00;
      eRx_r <= 8'h00;
      csN_r <= 1'b1;
      sclk_r <= 1'b0;
      mosi_r <= 1'b0;
      ext_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      ldPend_r <= 1'b0;
      ldAddr_r <= 16'h0000;
      ldData_r <= 8'h00;
    end else begin
      est_r <= est_nxt;
      kind_r <= kind_nxt;
      nk_r <= nk_nxt;
      bi_r <= bi_nxt;
      wCnt_r <= wCnt_nxt;
      div_r <= div_nxt;
      half_r <= half_nxt;
      eTx_r <= eTx_nxt;
      eRx_r <= eRx_nxt;
      csN_r <= csN_nxt;
      sclk_r <= sclk_nxt;
      mosi_r <= mosi_nxt;
      ext_r <= ext_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      ldPend_r <= ldPend_nxt;
      ldAddr_r <= ldAddr_nxt;
      ldData_r <= ldData_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // memory map write port and voltage code registers

  hsca_memwr_t memWr;
  logic vSampled_r;
  logic [5:0] pinCode_r, pinCode_nxt, hostCode_r, hostCode_nxt;

  // monitor first, then loader (held pending), host only when both idle
  always_comb begin
    memWr = hostWr;
    if (monWr.vld) memWr = monWr;
    else if (ldPend_r) memWr = '{vld: 1'b1, addr: ldAddr_r, data: ldData_r};
    pinCode_nxt = pinCode_r;
    hostCode_nxt = hostCode_r;
    if (!vSampled_r) begin
      pinCode_nxt = voltSelPins;
      hostCode_nxt = voltSelPins;
    end else if (softStartDone) begin
      pinCode_nxt = voltSelPins;
      if (memWr.vld && memWr.addr == VCODE_ADDR) hostCode_nxt = memWr.data[5:0];
      else if (voltSelPins != pinCode_r) hostCode_nxt = voltSelPins;
    end
  end

  always_ff @(posedge clock) begin
    if (memWr.vld && memWr.addr < 16'(MEM_DEPTH)) mem[memWr.addr[AW-1:0]] <= memWr.data;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vSampled_r <= 1'b0;
      pinCode_r <= 6'h00;
      hostCode_r <= 6'h00;
    end else begin
      vSampled_r <= 1'b1;
      pinCode_r <= pinCode_nxt;
      hostCode_r <= hostCode_nxt;
    end
  end

  assign hostTxd = hostTxd_r;
  assign eeCsN = csN_r;
  assign eeSclk = sclk_r;
  assign eeMosi = mosi_r;
  assign extMemPresent = ext_r;
  assign loadDone = done_r;
  assign voltTarget = hostCode_r;
  assign pinVoltCode = pinCode_r;
endmodule

// ==== test_host_serial_config_access.sv ====
// self-checking bench: host serial commands against the access block
// assumes a 200 MHz clock; the eeprom model answers the probe, load, write, status poll and read-back frames
`timescale 1ns/1ps
module test_host_serial_config_access;
  import hsca_pkg::*;
  // short bit time and time-out keep the run small; both are passed to the design as parameter overrides
  localparam int BIT = 40;
  localparam int TMO = 2000;
  localparam logic [5:0] PINS = 6'h2a;
  logic clock;
  logic reset_n;
  logic hostRxd;
  logic hostTxd;
  logic eeMiso;
  logic eeCsN;
  logic eeSclk;
  logic eeMosi;
  hsca_memwr_t monWr;
  logic [5:0] voltSel;
  logic softStartDone;
  logic [5:0] voltTarget;
  logic [5:0] pinVoltCode;
  logic extMemPresent;
  logic loadDone;
  int failures;
  int num_checks;
  int txFalls;
  logic [15:0] rx;

  hsca_top #(.TIMEOUT_CYCLES(TMO), .BIT_CYCLES(BIT)) DUT (
    .clock(clock), .reset_n(reset_n), .hostRxd(hostRxd), .hostTxd(hostTxd),
    .eeMiso(eeMiso), .eeCsN(eeCsN), .eeSclk(eeSclk), .eeMosi(eeMosi), .monWr(monWr),
    .voltSelPins(voltSel), .softStartDone(softStartDone), .voltTarget(voltTarget),
    .pinVoltCode(pinVoltCode), .extMemPresent(extMemPresent), .loadDone(loadDone)
  );
  hsca_ee_model EE (.eeCsN(eeCsN), .eeSclk(eeSclk), .eeMosi(eeMosi), .eeMiso(eeMiso));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // one count per character: data zeros also fall, so re-arm only in the middle of the stop bit
  initial begin
    forever begin
      @(negedge hostTxd);
      txFalls++;
      repeat (BIT * 19 / 2) @(posedge clock);
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // mon overlaps monitor writes to 0200 with the stop-bit sample
  task automatic send_byte(input logic [7:0] b, input bit mon);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      hostRxd = fr[i];
      if (i == 9 && mon) begin
        cyc(BIT / 2 - 6);
        monWr = '{1'b1, 16'h0200, 8'h11};
        cyc(16);
        monWr.vld = 1'b0;
        cyc(BIT / 2 - 10);
      end else cyc(BIT);
    end
  endtask

  task automatic recv_byte(output logic [7:0] b);
    int t;
    t = 0;
    while (hostTxd !== 1'b0 && t < 400000) begin
      @(negedge clock);
      t++;
    end
    repeat (BIT / 2) @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge clock);
      b[i] = hostTxd;
    end
    repeat (BIT) @(negedge clock);
    check("stop bit", 8'h01, {7'h00, hostTxd});
  endtask

  // bytes go lsb first out of tx; reply bytes land lsb first in got
  task automatic cmd(input logic [31:0] tx, input int ntx, input int nrx, input bit mon,
                     output logic [15:0] got);
    int f0;
    logic [7:0] b;
    f0 = txFalls;
    got = 16'h0000;
    fork
      for (int i = 0; i < ntx; i++) send_byte(tx[8*i +: 8], mon && i == ntx - 1);
      for (int j = 0; j < nrx; j++) begin
        recv_byte(b);
        got[8*j +: 8] = b;
      end
    join
    cyc(2 * BIT);
    check("reply byte count", 8'(nrx), 8'(txFalls - f0));
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    hostRxd = 1'b1;
    monWr = '0;
    voltSel = PINS;
    softStartDone = 1'b0;
    failures = 0;
    num_checks = 0;
    txFalls = 0;
    cyc(2);
    reset_n = 1'b1;
    cmd(32'h77094101, 4, 1, 1'b0, rx);
    check("stalled write error", ERR_NONE, rx[7:0]);
    check("write held for load", 8'h01, {7'h00, loadDone});
    check("early eeprom copy", 8'h77, EE.mem[8'h42]);
    for (int t = 0; t < 200000 && loadDone !== 1'b1; t++) cyc(1);
    check("load done", 8'h01, {7'h00, loadDone});
    check("memory present", 8'h01, {7'h00, extMemPresent});
    check("start target", {2'b00, PINS}, {2'b00, voltTarget});
    softStartDone = 1'b1;
    cmd(32'h5a020001, 4, 1, 1'b1, rx);
    check("write error", ERR_NONE, rx[7:0]);
    cmd(32'h00100000, 3, 1, 1'b0, rx);
    check("range error", ERR_BUS, rx[7:0]);
    cmd(32'h00100002, 3, 0, 1'b0, rx);
    cyc(TMO);
    cmd(32'h00020000, 3, 2, 1'b0, rx);
    check("read error", ERR_NONE, rx[7:0]);
    check("read data", 8'h5a, rx[15:8]);
    cmd(32'h3c094001, 4, 1, 1'b0, rx);
    check("nv write error", ERR_NONE, rx[7:0]);
    check("eeprom copy", 8'h3c, EE.mem[8'h41]);
    cmd(32'h00094000, 3, 2, 1'b0, rx);
    check("nv read data", 8'h3c, rx[15:8]);
    cmd(32'h15088001, 4, 1, 1'b0, rx);
    cyc(4);
    check("host target", 8'h15, {2'b00, voltTarget});
    check("pin code", {2'b00, PINS}, {2'b00, pinVoltCode});
    voltSel = 6'h0b;
    cyc(4);
    check("pin code follow", 8'h0b, {2'b00, pinVoltCode});
    check("pin target", 8'h0b, {2'b00, voltTarget});
    final_report();
  end

  initial begin
    #400_000;
    failures++;
    final_report();
  end
endmodule

bind hsca_top hsca_monitor #(.BIT_CYCLES(BIT_CYCLES)) MON (
  .clock(clock), .reset_n(reset_n), .hostTxd(hostTxd), .eeCsN(eeCsN), .eeSclk(eeSclk),
  .voltSelPins(voltSelPins), .softStartDone(softStartDone), .voltTarget(voltTarget),
  .pinVoltCode(pinVoltCode), .extMemPresent(extMemPresent), .loadDone(loadDone)
);
